// [include/efvc_defines.vh]
// Subaddresses, field positions, reset values and counts of the encoder control bank
`ifndef EFVC_DEFINES_VH
`define EFVC_DEFINES_VH

// ----------------------------------------------------------------
// Subaddresses
// ----------------------------------------------------------------
`define EFVC_ADDR_KEY2_U 8'h51
`define EFVC_ADDR_KEY2_V 8'h52
`define EFVC_ADDR_KEY2_Y 8'h53
`define EFVC_ADDR_IN_CTRL 8'h54
`define EFVC_ADDR_L16_B5 8'h55
`define EFVC_ADDR_L16_B11 8'h56
`define EFVC_ADDR_L16_B12 8'h57
`define EFVC_ADDR_L16_B13 8'h58
`define EFVC_ADDR_L16_B14 8'h59
`define EFVC_ADDR_SC_PHASE 8'h5a
`define EFVC_ADDR_GAIN_U 8'h5b

// ----------------------------------------------------------------
// Input-path control fields
// ----------------------------------------------------------------
`define EFVC_BIT_L16_EN 7
`define EFVC_BIT_UNUSED 6
`define EFVC_BIT_ENC_SRC 5
`define EFVC_BIT_RGB_SRC 4
`define EFVC_BIT_RSV_A 3
`define EFVC_BIT_RSV_B 2
`define EFVC_BIT_B_EDGE 1
`define EFVC_BIT_A_EDGE 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define EFVC_RST_KEY2 8'h80
`define EFVC_RST_IN_CTRL 8'h0c
`define EFVC_RST_L16 8'h00
`define EFVC_RST_SC_PHASE 8'h00
`define EFVC_RST_GAIN_U 8'h00

// ----------------------------------------------------------------
// Mixer full scale, line-16 bit count and component select codes
// ----------------------------------------------------------------
`define EFVC_FADE_FULL 6'h3f
`define EFVC_L16_BITS 6'h28
`define EFVC_COMP_U 2'h0
`define EFVC_COMP_Y 2'h1
`define EFVC_COMP_V 2'h2

`endif

// [logic/efvc_port_capture.v]
// Input-port capture on a selectable clock edge, followed by two-stage sync
module efvc_port_capture (
  // Clock, reset, enable
  input wire clk,
  input wire rst_b,
  input wire ce,
  // Edge select: 0 rising, 1 falling
  input wire falling_sel,
  // Pin side
  input wire [7:0] pin_data,
  // Core side
  output reg [7:0] data_q
);

  reg [7:0] rise_q;
  reg [7:0] fall_q;
  reg [7:0] rise_sync_q;
  reg [7:0] fall_sync_q;

  // Capture on both edges; first stages feed only their second stages
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rise_q <= 8'h00;
      rise_sync_q <= 8'h00;
      fall_sync_q <= 8'h00;
    end else if (ce) begin
      rise_q <= pin_data;
      rise_sync_q <= rise_q;
      fall_sync_q <= fall_q;
    end
  end

  // Falling-edge capture stage
  always @(negedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fall_q <= 8'h00;
    end else if (ce) begin
      fall_q <= pin_data;
    end
  end

  // Edge choice is made after the sync stages so no gate reads a first stage
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      data_q <= 8'h00;
    end else if (ce) begin
      data_q <= falling_sel ? fall_sync_q : rise_sync_q;
    end
  end

endmodule

// [logic/efvc_line16_serializer.v]
// Line-16 programming data serializer, five bytes sent LSB first
`include "efvc_defines.vh"

module efvc_line16_serializer (
  // Clock, reset, enable
  input wire clk,
  input wire rst_b,
  input wire ce,
  // Control from the register bank
  input wire insert_en,
  input wire [39:0] payload,
  // Timing from the line-16 inserter
  input wire line_start,
  input wire bit_tick,
  // Serial output
  output wire ser_bit,
  output reg ser_active_q
);

  reg [39:0] shift_q;
  reg [5:0] left_q;

  assign ser_bit = shift_q[0];

  // Load on line start, shift one bit per tick; dropping the enable aborts
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_q <= 40'h00_0000_0000;
      left_q <= 6'h00;
      ser_active_q <= 1'b0;
    end else if (ce) begin
      if (!insert_en) begin
        ser_active_q <= 1'b0;
        left_q <= 6'h00;
      end else if (line_start && !ser_active_q) begin
        shift_q <= payload;
        left_q <= `EFVC_L16_BITS;
        ser_active_q <= 1'b1;
      end else if (ser_active_q && bit_tick) begin
        shift_q <= {1'b0, shift_q[39:1]};
        left_q <= left_q - 6'h01;
        if (left_q == 6'h01) begin
          ser_active_q <= 1'b0;
        end
      end
    end
  end

endmodule

// [logic/efvc_regs.v]
// Fader key-colour table, input-path, line-16 data, phase and gain registers
//
// Functional notes
// - On key colour 2, insert stored U, V, Y table values; each resets to 80h.
// - Line-16 data is inserted only while the enable bit is 1; reset clears it.
// - Encoder path takes port B when select is 0, fader output when 1.
// - RGB path takes port B when select is 0, fader output when 1.
// - Port B sampled on rising edge when its edge bit is 0, else falling.
// - Port A sampled on rising edge when its edge bit is 0, else falling.
// - Line-16 bytes five, eleven to fourteen come from 55h to 59h in order.
// - Each line-16 data byte is sent least significant bit first.
// - 8-bit code sets subcarrier phase to sync, 360/256 degrees per step.
// - 9-bit blue gain is 8 low bits here plus MSB from 5Dh.
// - Key colour 2 mixes table and video by 6-bit factor; 00h table, 3Fh video.
// - Fade-all mode fades whole selected stream with table colour, keying off.
`include "efvc_defines.vh"

module efvc_regs (
  // Clock, reset, enable
  input wire clk,
  input wire rst_b,
  input wire ce,
  // Subaddress register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  output reg reg_rd_valid,
  // Multiplexed input port pins
  input wire [7:0] input_port_a,
  input wire [7:0] input_port_b,
  // Fader context from neighbouring logic, same clock
  input wire [1:0] comp_sel,
  input wire key2_hit,
  input wire [7:0] fader_base,
  input wire [5:0] key2_mix_factor,
  input wire fade_all_video_mode,
  input wire fade_all_compressed_mode,
  // Line-16 timing from the inserter
  input wire line16_start,
  input wire line16_bit_tick,
  // Gain MSB held in the neighbouring register
  input wire blue_diff_gain_msb,
  // Video outputs
  output reg [7:0] encoder_data,
  output reg [7:0] rgb_data,
  // Line-16 serial data
  output wire line16_bit,
  output wire line16_active,
  // Encoder settings
  output wire line16_insert_enable,
  output wire [7:0] subcarrier_sync_phase,
  output wire [8:0] blue_diff_gain
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  reg [7:0] key2_replace_u_q;
  reg [7:0] key2_replace_v_q;
  reg [7:0] key2_replace_y_q;
  reg [7:0] input_path_control_q;
  reg [7:0] line16_data_byte5_q;
  reg [7:0] line16_data_byte11_q;
  reg [7:0] line16_data_byte12_q;
  reg [7:0] line16_data_byte13_q;
  reg [7:0] line16_data_byte14_q;
  reg [7:0] subcarrier_sync_phase_q;
  reg [7:0] blue_diff_gain_low_q;

  // Datapath state
  reg [7:0] fader_q;
  reg [7:0] port_b_dly_q;
  wire [7:0] port_a_data;
  wire [7:0] port_b_data;

  // Mixer scratch
  reg [7:0] lut_pick;
  reg [7:0] mix_src;
  reg mix_on;
  reg [7:0] fader_d;
  reg [7:0] rdata_d;

  // ----------------------------------------------------------------
  // Fade mixer: exact at both ends of the factor range
  // ----------------------------------------------------------------
  // Dividing by 63 rather than shifting keeps 3Fh at pure video
  function [7:0] efvc_mix;
    input [5:0] factor;
    input [7:0] video;
    input [7:0] table_val;
    reg [13:0] sum;
    begin
      sum = ({8'h00, factor} * {6'h00, video})
        + ({8'h00, `EFVC_FADE_FULL - factor} * {6'h00, table_val})
        + 14'd31;
      sum = sum / 14'd63;
      efvc_mix = sum[7:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Reserved and unused control bits are stored as written
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      key2_replace_u_q <= `EFVC_RST_KEY2;
      key2_replace_v_q <= `EFVC_RST_KEY2;
      key2_replace_y_q <= `EFVC_RST_KEY2;
      input_path_control_q <= `EFVC_RST_IN_CTRL;
      line16_data_byte5_q <= `EFVC_RST_L16;
      line16_data_byte11_q <= `EFVC_RST_L16;
      line16_data_byte12_q <= `EFVC_RST_L16;
      line16_data_byte13_q <= `EFVC_RST_L16;
      line16_data_byte14_q <= `EFVC_RST_L16;
      subcarrier_sync_phase_q <= `EFVC_RST_SC_PHASE;
      blue_diff_gain_low_q <= `EFVC_RST_GAIN_U;
    end else if (ce && reg_wr) begin
      if (reg_addr == `EFVC_ADDR_KEY2_U) begin
        key2_replace_u_q <= reg_wdata;
      end else if (reg_addr == `EFVC_ADDR_KEY2_V) begin
        key2_replace_v_q <= reg_wdata;
      end else if (reg_addr == `EFVC_ADDR_KEY2_Y) begin
        key2_replace_y_q <= reg_wdata;
      end else if (reg_addr == `EFVC_ADDR_IN_CTRL) begin
        input_path_control_q <= reg_wdata;
      end else if (reg_addr == `EFVC_ADDR_L16_B5) begin
        line16_data_byte5_q <= reg_wdata;
      end else if (reg_addr == `EFVC_ADDR_L16_B11) begin
        line16_data_byte11_q <= reg_wdata;
      end else if (reg_addr == `EFVC_ADDR_L16_B12) begin
        line16_data_byte12_q <= reg_wdata;
      end else if (reg_addr == `EFVC_ADDR_L16_B13) begin
        line16_data_byte13_q <= reg_wdata;
      end else if (reg_addr == `EFVC_ADDR_L16_B14) begin
        line16_data_byte14_q <= reg_wdata;
      end else if (reg_addr == `EFVC_ADDR_SC_PHASE) begin
        subcarrier_sync_phase_q <= reg_wdata;
      end else if (reg_addr == `EFVC_ADDR_GAIN_U) begin
        blue_diff_gain_low_q <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Unmapped subaddresses read as zero
  always @* begin
    rdata_d = 8'h00;
    if (reg_addr == `EFVC_ADDR_KEY2_U) begin
      rdata_d = key2_replace_u_q;
    end else if (reg_addr == `EFVC_ADDR_KEY2_V) begin
      rdata_d = key2_replace_v_q;
    end else if (reg_addr == `EFVC_ADDR_KEY2_Y) begin
      rdata_d = key2_replace_y_q;
    end else if (reg_addr == `EFVC_ADDR_IN_CTRL) begin
      rdata_d = input_path_control_q;
    end else if (reg_addr == `EFVC_ADDR_L16_B5) begin
      rdata_d = line16_data_byte5_q;
    end else if (reg_addr == `EFVC_ADDR_L16_B11) begin
      rdata_d = line16_data_byte11_q;
    end else if (reg_addr == `EFVC_ADDR_L16_B12) begin
      rdata_d = line16_data_byte12_q;
    end else if (reg_addr == `EFVC_ADDR_L16_B13) begin
      rdata_d = line16_data_byte13_q;
    end else if (reg_addr == `EFVC_ADDR_L16_B14) begin
      rdata_d = line16_data_byte14_q;
    end else if (reg_addr == `EFVC_ADDR_SC_PHASE) begin
      rdata_d = subcarrier_sync_phase_q;
    end else if (reg_addr == `EFVC_ADDR_GAIN_U) begin
      rdata_d = blue_diff_gain_low_q;
    end
  end

  // Read data is registered one cycle after the strobe
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else if (ce) begin
      reg_rd_valid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Input ports
  // ----------------------------------------------------------------
  efvc_port_capture u_port_a (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .falling_sel(input_path_control_q[`EFVC_BIT_A_EDGE]),
    .pin_data(input_port_a),
    .data_q(port_a_data)
  );

  efvc_port_capture u_port_b (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .falling_sel(input_path_control_q[`EFVC_BIT_B_EDGE]),
    .pin_data(input_port_b),
    .data_q(port_b_data)
  );

  // ----------------------------------------------------------------
  // Key colour 2 fader
  // ----------------------------------------------------------------
  // Table entry follows the component now on the multiplexed stream
  always @* begin
    lut_pick = key2_replace_y_q;
    if (comp_sel == `EFVC_COMP_U) begin
      lut_pick = key2_replace_u_q;
    end else if (comp_sel == `EFVC_COMP_V) begin
      lut_pick = key2_replace_v_q;
    end
  end

  // Fade-all overrides keying; otherwise only a key 2 hit mixes
  always @* begin
    mix_src = port_a_data;
    mix_on = 1'b0;
    if (fade_all_video_mode) begin
      mix_src = port_a_data;
      mix_on = 1'b1;
    end else if (fade_all_compressed_mode) begin
      mix_src = port_b_data;
      mix_on = 1'b1;
    end else if (key2_hit) begin
      mix_src = port_a_data;
      mix_on = 1'b1;
    end
    fader_d = mix_on ? efvc_mix(key2_mix_factor, mix_src, lut_pick) : fader_base;
  end

  // Port B is delayed one cycle so both path sources share one latency
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fader_q <= 8'h00;
      port_b_dly_q <= 8'h00;
    end else if (ce) begin
      fader_q <= fader_d;
      port_b_dly_q <= port_b_data;
    end
  end

  // ----------------------------------------------------------------
  // Output path selection
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      encoder_data <= 8'h00;
      rgb_data <= 8'h00;
    end else if (ce) begin
      if (input_path_control_q[`EFVC_BIT_ENC_SRC]) begin
        encoder_data <= fader_q;
      end else begin
        encoder_data <= port_b_dly_q;
      end
      if (input_path_control_q[`EFVC_BIT_RGB_SRC]) begin
        rgb_data <= fader_q;
      end else begin
        rgb_data <= port_b_dly_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Line-16 programming data
  // ----------------------------------------------------------------
  assign line16_insert_enable = input_path_control_q[`EFVC_BIT_L16_EN];

  efvc_line16_serializer u_line16 (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .insert_en(line16_insert_enable),
    .payload({line16_data_byte14_q, line16_data_byte13_q, line16_data_byte12_q,
      line16_data_byte11_q, line16_data_byte5_q}),
    .line_start(line16_start),
    .bit_tick(line16_bit_tick),
    .ser_bit(line16_bit),
    .ser_active_q(line16_active)
  );

  // ----------------------------------------------------------------
  // Phase and gain settings
  // ----------------------------------------------------------------
  // Code drives the phase accumulator offset directly, one LSB per 360/256 deg
  assign subcarrier_sync_phase = subcarrier_sync_phase_q;
  assign blue_diff_gain = {blue_diff_gain_msb, blue_diff_gain_low_q};

endmodule

// [tb/efvc_regs_props.sv]
// Concurrent checks on the encoder control register bank ports
module efvc_regs_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  // Line-16 and encoder settings
  input wire logic line16_start,
  input wire logic line16_active,
  input wire logic line16_insert_enable,
  input wire logic [7:0] subcarrier_sync_phase,
  input wire logic [8:0] blue_diff_gain,
  input wire logic blue_diff_gain_msb
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // Request sequences
  // ----------------------------------------------------------------
  sequence s_read;
    ce && reg_rd;
  endsequence
  sequence s_wr(a);
    ce && reg_wr && reg_addr == a;
  endsequence
  sequence s_start;
    ce && line16_insert_enable && line16_start && !line16_active;
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_read_answers: assert property (s_read |=> reg_rd_valid)
    else $error("read strobe not answered");
  a_valid_one_shot: assert property (ce && !reg_rd |=> !reg_rd_valid)
    else $error("read valid without read");
  a_unmapped_zero: assert property (s_read ##0 (reg_addr < 8'h51 || reg_addr > 8'h5b)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_rdata_holds: assert property (ce && !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_phase_write: assert property (
    s_wr(8'h5a) |=> subcarrier_sync_phase == $past(reg_wdata))
    else $error("phase code not taken");
  a_gain_low: assert property (
    s_wr(8'h5b) |=> blue_diff_gain[7:0] == $past(reg_wdata))
    else $error("gain low bits not taken");
  a_gain_msb: assert property (blue_diff_gain[8] == blue_diff_gain_msb)
    else $error("gain msb not joined");
  a_enable_write: assert property (
    s_wr(8'h54) |=> line16_insert_enable == $past(reg_wdata[7]))
    else $error("insert enable not taken");
  a_off_silent: assert property (!line16_insert_enable |=> !line16_active)
    else $error("line16 active while disabled");
  a_start_runs: assert property (s_start |=> line16_active)
    else $error("line16 frame did not start");
endmodule

bind efvc_regs efvc_regs_chk chk (
  .clk(clk), .rst_b(rst_b), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rd_valid(reg_rd_valid), .line16_start(line16_start),
  .line16_active(line16_active), .line16_insert_enable(line16_insert_enable),
  .subcarrier_sync_phase(subcarrier_sync_phase), .blue_diff_gain(blue_diff_gain),
  .blue_diff_gain_msb(blue_diff_gain_msb)
);

// [tb/efvc_host.sv]
// Host model driving the subaddress register port of the control bank
module efvc_host (
  // Clock
  input wire logic clk,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // Recommended phase codes: PAL ports, PAL table, NTSC ports, NTSC table
  logic [7:0] ph [4] = '{8'h0f, 8'h3a, 8'h35, 8'h57};
  // Idle bus
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Single byte write; lines scrambled after so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Single byte read with a bounded wait for the answer
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int i;
    d = 8'h00;
    ok = 1'b0;
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    for (i = 0; i < 4 && !ok; i++) begin
      if (reg_rd_valid === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata;
      end else begin
        @(negedge clk);
      end
    end
  endtask
  // Input-path control byte; unused bit low, reserved pair high
  task automatic ctrl(input logic en, enc, rgb, be, ae);
    wr(8'h54, {en, 1'b0, enc, rgb, 1'b1, 1'b1, be, ae});
  endtask
endmodule

// [tb/encoder_fader_vps_control_regs_test.sv]
// Self-checking bench for the encoder control register bank
`include "efvc_defines.vh"
module encoder_fader_vps_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [7:0] port_a = 8'h00, port_b = 8'h00, base = 8'h00, d;
  logic [1:0] comp_sel = 2'h0;
  logic [5:0] mix = 6'h00;
  logic hit = 1'b0, fav = 1'b0, fac = 1'b0, start = 1'b0, tick = 1'b0, msb = 1'b0, ok;
  logic [39:0] pay = {8'ha8, 8'ha7, 8'ha6, 8'ha5, 8'ha4};
  logic [7:0] tbl [3] = '{8'ha0, 8'ha2, 8'ha1};
  logic [7:0] rst_val [11] = '{`EFVC_RST_KEY2, `EFVC_RST_KEY2, `EFVC_RST_KEY2,
    `EFVC_RST_IN_CTRL, `EFVC_RST_L16, `EFVC_RST_L16, `EFVC_RST_L16, `EFVC_RST_L16,
    `EFVC_RST_L16, `EFVC_RST_SC_PHASE, `EFVC_RST_GAIN_U};
  wire reg_wr, reg_rd, valid, l16_bit, l16_act, l16_en;
  wire [7:0] reg_addr, reg_wdata, rdata, enc, rgb, phase;
  wire [8:0] gain;
  int err_count = 0, compares = 0, i;
  // 20 MHz clock
  always #25 clk = ~clk;
  efvc_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_rd_valid(valid));
  efvc_regs dut (.clk(clk), .rst_b(rst_b), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_rd_valid(valid),
    .input_port_a(port_a), .input_port_b(port_b), .comp_sel(comp_sel), .key2_hit(hit),
    .fader_base(base), .key2_mix_factor(mix), .fade_all_video_mode(fav),
    .fade_all_compressed_mode(fac), .line16_start(start), .line16_bit_tick(tick),
    .blue_diff_gain_msb(msb), .encoder_data(enc), .rgb_data(rgb), .line16_bit(l16_bit),
    .line16_active(l16_act), .line16_insert_enable(l16_en),
    .subcarrier_sync_phase(phase), .blue_diff_gain(gain));
  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    if (err_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Read and compare; a missing answer counts as a hang
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, d, ok);
    if (ok !== 1'b1) begin
      err_count++;
      summarize();
    end else begin
      chk({1'b0, d}, {1'b0, exp});
    end
  endtask
  // Static pins, so wait out the pipe rather than count its stages
  task automatic vid(input logic [7:0] e, input logic [7:0] r);
    repeat (8) @(negedge clk);
    chk({1'b0, enc}, {1'b0, e});
    chk({1'b0, rgb}, {1'b0, r});
  endtask
  // Pins change by a rising edge, so a falling capture gets them half a cycle sooner
  task automatic edge_lat(input logic [7:0] v, input logic [7:0] e, input logic [7:0] r);
    @(posedge clk);
    port_a <= v;
    port_b <= v;
    repeat (5) @(negedge clk);
    chk({1'b0, enc}, {1'b0, e});
    chk({1'b0, rgb}, {1'b0, r});
    repeat (3) @(negedge clk);
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    // Reset values, then unmapped places
    for (i = 0; i < 11; i++) rchk(8'h51 + i[7:0], rst_val[i]);
    host.wr(8'h50, 8'h55);
    rchk(8'h50, 8'h00);
    rchk(8'h60, 8'h00);
    // Distinct byte everywhere except the input-path control
    for (i = 0; i < 11; i++) if (i != 3) host.wr(8'h51 + i[7:0], 8'ha0 + i[7:0]);
    for (i = 0; i < 11; i++) rchk(8'h51 + i[7:0], i == 3 ? 8'h0c : 8'ha0 + i[7:0]);
    msb = 1'b1;
    @(negedge clk);
    chk(gain, 9'h1aa);
    for (i = 0; i < 4; i++) begin
      host.wr(8'h5a, host.ph[i]);
      chk({1'b0, phase}, {1'b0, host.ph[i]});
    end
    // Clock enable low: the write strobe must be ignored
    ce = 1'b0;
    host.wr(8'h5a, 8'h11);
    ce = 1'b1;
    chk({1'b0, phase}, 9'h057);
    // Path selects; edge bits set but pins static
    port_b = 8'h5a;
    base = 8'h3c;
    port_a = 8'h40;
    host.ctrl(0, 0, 0, 0, 0);
    vid(8'h5a, 8'h5a);
    host.ctrl(0, 1, 0, 1, 0);
    vid(8'h3c, 8'h5a);
    host.ctrl(0, 0, 1, 0, 1);
    vid(8'h5a, 8'h3c);
    // Key colour 2: table value per component at no video share, then factors 3Fh and 20h
    host.ctrl(0, 1, 1, 0, 0);
    hit = 1'b1;
    for (i = 0; i < 3; i++) begin
      comp_sel = i[1:0];
      vid(tbl[i], tbl[i]);
    end
    comp_sel = 2'h0;
    mix = 6'h3f;
    host.ctrl(0, 1, 1, 0, 1);
    vid(8'h40, 8'h40);
    host.wr(8'h51, 8'hc0);
    mix = 6'h20;
    vid(8'h7f, 8'h7f);
    // Fade-all modes with the key detector idle
    hit = 1'b0;
    mix = 6'h00;
    fav = 1'b1;
    vid(8'hc0, 8'hc0);
    fav = 1'b0;
    fac = 1'b1;
    vid(8'hc0, 8'hc0);
    mix = 6'h3f;
    vid(8'h5a, 8'h5a);
    fac = 1'b0;
    // Sampling edges: with full video share the fader passes port A through
    fav = 1'b1;
    host.ctrl(0, 1, 0, 1, 0);
    vid(8'h40, 8'h5a);
    edge_lat(8'h33, 8'h40, 8'h33);
    host.ctrl(0, 1, 0, 0, 1);
    vid(8'h33, 8'h33);
    edge_lat(8'h44, 8'h44, 8'h33);
    fav = 1'b0;
    // Full line-16 frame, forty bits
    host.ctrl(1, 0, 0, 0, 0);
    chk({8'h00, l16_en}, 9'h001);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    chk({8'h00, l16_act}, 9'h001);
    for (i = 0; i < 40; i++) begin
      chk({8'h00, l16_bit}, {8'h00, pay[i]});
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
      @(negedge clk);
    end
    @(negedge clk);
    chk({8'h00, l16_act}, 9'h000);
    // Abort right after a frame starts, before any bit tick, then a start while disabled
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    host.ctrl(0, 0, 0, 0, 0);
    @(negedge clk);
    chk({8'h00, l16_act}, 9'h000);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    @(negedge clk);
    chk({8'h00, l16_act}, 9'h000);
    summarize();
  end
endmodule
